// ==== shared/ssrw_pkg.sv ====
package ssrw_pkg;
   // Timebase
   localparam int unsigned CLK_HZ = 40_000_000;
   localparam int unsigned CLK_NS = 25;
   // Reset release delay, nominal
   localparam int unsigned RST_DELAY_MS = 200;
   localparam int unsigned RST_DELAY_CYC = RST_DELAY_MS * (CLK_HZ / 1000);
   // Watchdog timeout
   localparam int unsigned WDOG_TIMEOUT_MS = 1600;
   localparam int unsigned WDOG_TIMEOUT_CYC = WDOG_TIMEOUT_MS * (CLK_HZ / 1000);
   // Manual reset least low time seen by the host driver
   localparam int unsigned MR_MIN_NS = 500;
   localparam int unsigned MR_MIN_CYC = (MR_MIN_NS + CLK_NS - 1) / CLK_NS;
   // Counter width covering both long counts
   localparam int unsigned CNT_W = 27;
   // Reset output polarity options
   typedef enum logic [1:0] {
      SSRW_POL_HIGH,
      SSRW_POL_LOW,
      SSRW_POL_BOTH
   } ssrw_pol_t;
endpackage : ssrw_pkg

// ==== shared/ssrw_if.sv ====
`timescale 1ns/1ps
interface ssrw_if;
   logic rst;            // Active-high reset output
   logic rst_n;          // Active-low reset output
   logic wdog_expired_n; // Watchdog expiry, active low
   logic pwr_fail_warn_n;
   logic wdog_kick_in;   // Kick level driven by host
   logic wdog_kick_oe;   // High while host drives kick pin
   logic manual_reset_n;
   modport dev (
      output rst, rst_n, wdog_expired_n, pwr_fail_warn_n,
      input wdog_kick_in, wdog_kick_oe, manual_reset_n
   );
   modport host (
      input rst, rst_n, wdog_expired_n, pwr_fail_warn_n,
      output wdog_kick_in, wdog_kick_oe, manual_reset_n
   );
endinterface : ssrw_if

// ==== verilog/ssrw_sync.sv ====
`timescale 1ns/1ps
module ssrw_sync (
   input wire logic i_ref_clk,
   input wire logic i_srst,
   input wire logic i_d,
   output logic o_q
);
   logic meta;
   logic next_meta;
   logic next_q;

   // Two-stage capture
   always_comb begin
      next_meta = i_srst ? 1'b1 : i_d;
      next_q = i_srst ? 1'b1 : meta;
   end

   always_ff @(posedge i_ref_clk) begin
      meta <= next_meta;
      o_q <= next_q;
   end
endmodule : ssrw_sync

// ==== verilog/ssrw_device.sv ====
`timescale 1ns/1ps
// How it works
// - Reset held while low supply, then delay
// - Low supply asserts reset, clears timer
// - Interruption restarts the full release delay
// - Build option selects reset output polarity
// - No kick within timeout drives expiry low
// - Watchdog counter zero while reset asserted
// - Watchdog counts from zero after release
// - Floating kick disables watchdog in variant
// - Disable only while expiry not asserted
// - Low supply forces expiry low at once
// - Timeout holds until kick; any reset releases
// - Host routes expiry to manual reset
// - Manual reset low asserts both outputs when POLARITY is SSRW_POL_BOTH
// - Reset held through manual low plus delay
// - Release delay debounces switch bounce
// - Host holds manual reset low long enough
// - Power-fail warning low below reference
// - Host treats warning as shutdown interrupt
// - Host may tie warning to manual reset
module ssrw_device #(
   parameter ssrw_pkg::ssrw_pol_t POLARITY = ssrw_pkg::SSRW_POL_BOTH,
   parameter bit WDOG_CAN_DISABLE = 1'b1,
   parameter int unsigned RST_CYC = ssrw_pkg::RST_DELAY_CYC,
   parameter int unsigned WDOG_CYC = ssrw_pkg::WDOG_TIMEOUT_CYC
) (
   input wire logic i_ref_clk,
   input wire logic i_srst,
   input wire logic i_supply_low,
   input wire logic i_pwr_fail_sense_low,
   ssrw_if.dev bus
);
   import ssrw_pkg::*;

   logic supply_low;
   logic sense_low;
   logic mr_n;
   logic kick;
   logic kick_en;
   logic kick_prev;
   logic next_kick_prev;
   logic [CNT_W-1:0] rst_cnt;
   logic [CNT_W-1:0] next_rst_cnt;
   logic rst_act;
   logic next_rst_act;
   logic [CNT_W-1:0] wd_cnt;
   logic [CNT_W-1:0] next_wd_cnt;
   logic wd_timeout;
   logic next_wd_timeout;
   logic pfw_n;
   logic next_pfw_n;
   logic rst_o;
   logic rst_n_o;
   logic next_rst_o;
   logic next_rst_n_o;
   logic wdo_n;
   logic next_wdo_n;
   logic kick_edge;
   logic wd_off;

   ////////////////////////////////////////////////////////////////////////////
   // Input capture, all async pins through two flops
   ssrw_sync u_sync_sup (.i_ref_clk(i_ref_clk), .i_srst(1'b0), .i_d(~i_supply_low),
      .o_q(supply_low));
   ssrw_sync u_sync_pfi (.i_ref_clk(i_ref_clk), .i_srst(1'b0), .i_d(~i_pwr_fail_sense_low),
      .o_q(sense_low));
   ssrw_sync u_sync_mr (.i_ref_clk(i_ref_clk), .i_srst(i_srst), .i_d(bus.manual_reset_n),
      .o_q(mr_n));
   ssrw_sync u_sync_kick (.i_ref_clk(i_ref_clk), .i_srst(i_srst), .i_d(bus.wdog_kick_in),
      .o_q(kick));
   ssrw_sync u_sync_koe (.i_ref_clk(i_ref_clk), .i_srst(i_srst), .i_d(bus.wdog_kick_oe),
      .o_q(kick_en));

   ////////////////////////////////////////////////////////////////////////////
   // Reset timer: cond holds it clear, releases after full delay
   logic rst_cond;
   assign rst_cond = ~supply_low | ~mr_n;

   always_comb begin
      next_rst_cnt = rst_cnt;
      next_rst_act = rst_act;
      if (rst_cond) begin
         next_rst_cnt = '0;
         next_rst_act = 1'b1;
      end else if (rst_act) begin
         if (rst_cnt >= CNT_W'(RST_CYC - 1)) begin
            next_rst_act = 1'b0;
            next_rst_cnt = '0;
         end else begin
            next_rst_cnt = rst_cnt + 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Watchdog: edge detect, counter, expiry latch
   assign kick_edge = kick ^ kick_prev;
   assign wd_off = WDOG_CAN_DISABLE && !kick_en && !wd_timeout;

   always_comb begin
      next_kick_prev = kick;
      next_wd_cnt = wd_cnt;
      next_wd_timeout = wd_timeout;
      if (next_rst_act || rst_act) begin
         next_wd_cnt = '0;
         next_wd_timeout = 1'b0;
      end else if (kick_edge && (kick_en || !WDOG_CAN_DISABLE)) begin
         next_wd_cnt = '0;
         next_wd_timeout = 1'b0;
      end else if (wd_off) begin
         next_wd_cnt = '0;
      end else if (!wd_timeout) begin
         if (wd_cnt >= CNT_W'(WDOG_CYC - 1)) begin
            next_wd_timeout = 1'b1;
            next_wd_cnt = '0;
         end else begin
            next_wd_cnt = wd_cnt + 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Output values
   always_comb begin
      next_rst_o = (POLARITY == SSRW_POL_LOW) ? 1'b0 : next_rst_act;
      next_rst_n_o = (POLARITY == SSRW_POL_HIGH) ? 1'b1 : ~next_rst_act;
      next_wdo_n = ~(next_wd_timeout | ~supply_low);
      next_pfw_n = sense_low; // Synced value is high while sense is above reference
   end

   // State registers
   always_ff @(posedge i_ref_clk) begin
      if (i_srst) begin
         rst_cnt <= '0;
         rst_act <= 1'b1;
         wd_cnt <= '0;
         wd_timeout <= 1'b0;
         kick_prev <= 1'b1;
         rst_o <= (POLARITY != SSRW_POL_LOW);
         rst_n_o <= (POLARITY == SSRW_POL_HIGH);
         wdo_n <= 1'b1;
         pfw_n <= 1'b1;
      end else begin
         rst_cnt <= next_rst_cnt;
         rst_act <= next_rst_act;
         wd_cnt <= next_wd_cnt;
         wd_timeout <= next_wd_timeout;
         kick_prev <= next_kick_prev;
         rst_o <= next_rst_o;
         rst_n_o <= next_rst_n_o;
         wdo_n <= next_wdo_n;
         pfw_n <= next_pfw_n;
      end
   end

   // Pin drive
   assign bus.rst = rst_o;
   assign bus.rst_n = rst_n_o;
   assign bus.wdog_expired_n = wdo_n;
   assign bus.pwr_fail_warn_n = pfw_n;
endmodule : ssrw_device

// ==== verilog/ssrw_host.sv ====
`timescale 1ns/1ps
module ssrw_host #(
   parameter bit TIE_WDO_TO_MR = 1'b1,
   parameter bit TIE_PFW_TO_MR = 1'b0
) (
   input wire logic i_ref_clk,
   input wire logic i_srst,
   input wire logic i_kick_toggle,
   input wire logic i_kick_float,
   input wire logic i_button_press,
   output logic o_cpu_reset,
   output logic o_nmi,
   output logic o_pwr_irq,
   ssrw_if.host bus
);
   import ssrw_pkg::*;

   logic [7:0] mr_cnt;
   logic [7:0] next_mr_cnt;
   logic kick_lvl;
   logic next_kick_lvl;
   logic rst_s;
   logic wdo_s;
   logic pfw_s;
   logic next_cpu_reset;
   logic next_nmi;
   logic next_pwr_irq;

   ////////////////////////////////////////////////////////////////////////////
   // Device pins through two flops
   ssrw_sync u_sync_rst (.i_ref_clk(i_ref_clk), .i_srst(i_srst), .i_d(bus.rst_n),
      .o_q(rst_s));
   ssrw_sync u_sync_wdo (.i_ref_clk(i_ref_clk), .i_srst(i_srst), .i_d(bus.wdog_expired_n),
      .o_q(wdo_s));
   ssrw_sync u_sync_pfw (.i_ref_clk(i_ref_clk), .i_srst(i_srst), .i_d(bus.pwr_fail_warn_n),
      .o_q(pfw_s));

   // Manual reset stretch and kick toggle
   always_comb begin
      next_kick_lvl = kick_lvl ^ i_kick_toggle;
      next_mr_cnt = (mr_cnt != 8'h00) ? mr_cnt - 8'h01 : 8'h00;
      if (i_button_press || (TIE_WDO_TO_MR && !bus.wdog_expired_n)
          || (TIE_PFW_TO_MR && !bus.pwr_fail_warn_n)) begin
         next_mr_cnt = 8'(MR_MIN_CYC);
      end
      next_cpu_reset = ~rst_s;
      next_nmi = ~wdo_s & rst_s;
      next_pwr_irq = ~pfw_s;
   end

   // Registers
   always_ff @(posedge i_ref_clk) begin
      if (i_srst) begin
         mr_cnt <= 8'h00;
         kick_lvl <= 1'b0;
         o_cpu_reset <= 1'b1;
         o_nmi <= 1'b0;
         o_pwr_irq <= 1'b0;
      end else begin
         mr_cnt <= next_mr_cnt;
         kick_lvl <= next_kick_lvl;
         o_cpu_reset <= next_cpu_reset;
         o_nmi <= next_nmi;
         o_pwr_irq <= next_pwr_irq;
      end
   end

   assign bus.manual_reset_n = (mr_cnt == 8'h00);
   assign bus.wdog_kick_in = kick_lvl;
   assign bus.wdog_kick_oe = ~i_kick_float;
endmodule : ssrw_host

// ==== tb/ssrw_asserts.sv ====
`timescale 1ns/1ps
module ssrw_asserts #(
   parameter int unsigned RST_CYC = 100,
   parameter int unsigned WDOG_CYC = 300
) (
   input wire logic i_ref_clk,
   input wire logic i_srst,
   input wire logic rst,
   input wire logic rst_n,
   input wire logic wdog_expired_n,
   input wire logic wdog_kick_in,
   input wire logic wdog_kick_oe,
   input wire logic manual_reset_n
);
   logic [15:0] mr_age;
   logic [15:0] wd_age;
   logic kick_d;
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (i_srst);
   // Cycles since manual reset low and since kick
   always_ff @(posedge i_ref_clk) begin
      kick_d <= wdog_kick_in;
      mr_age <= (i_srst || !manual_reset_n) ? 16'h0000 : mr_age + 16'h0001;
      wd_age <= (i_srst || rst || !wdog_kick_oe || kick_d != wdog_kick_in) ? 16'h0000
         : wd_age + 16'h0001;
   end
   //////////////////////////////////////////////////////////////////////
   chk_pol_pair: assert property (rst_n == !rst) else $error("rst pair differs");
   chk_mr_assert: assert property (!manual_reset_n [*4] |-> rst)
      else $error("manual reset not seen");
   chk_rel_delay: assert property ($fell(rst) |-> mr_age >= RST_CYC)
      else $error("reset released early");
   chk_wd_late: assert property (wd_age == WDOG_CYC |-> ##[0:8] !wdog_expired_n)
      else $error("watchdog missed expiry");
   chk_wd_early: assert property ($fell(wdog_expired_n) && wd_age < WDOG_CYC |-> ##[0:2] rst)
      else $error("expiry too early");
   chk_wd_hold: assert property ($rose(wdog_expired_n) && !rst && !$past(rst) |-> wd_age < 8)
      else $error("expiry cleared without kick");
   chk_dis_gate: assert property (!wdog_expired_n && !wdog_kick_oe && !rst
      |=> !wdog_expired_n || rst) else $error("disabled while expired");
   chk_tie_mr: assert property ($fell(wdog_expired_n) && !rst |-> ##[0:4] !manual_reset_n)
      else $error("expiry not routed");
   chk_mr_width: assert property ($fell(manual_reset_n) |-> !manual_reset_n [*8])
      else $error("manual reset too short");
   cov_timeout: cover property ($fell(wdog_expired_n) && !rst);
   cov_release: cover property ($fell(rst));
   cov_kick_clr: cover property ($rose(wdog_expired_n) && !rst);
endmodule : ssrw_asserts

// ==== tb/ssrw_tb_top.sv ====
`timescale 1ns/1ps
module ssrw_tb_top;
   import ssrw_pkg::*;
   localparam int RC = 100;
   localparam int WC = 300;
   logic i_ref_clk = 0, i_srst = 1, sup = 0, pfs = 0, tog = 0, flt = 0, btn = 0, irq;
   logic cpu_rst, nmi;
   int error_cnt = 0, n_checks = 0, cyc_n = 0, per = 64, last_k = 0, i, n;
   ssrw_if bus();
   ssrw_device #(.RST_CYC(RC), .WDOG_CYC(WC)) i_ssrw_device (.i_ref_clk(i_ref_clk),
      .i_srst(i_srst), .i_supply_low(sup), .i_pwr_fail_sense_low(pfs), .bus(bus));
   ssrw_host i_ssrw_host (.i_ref_clk(i_ref_clk), .i_srst(i_srst), .i_kick_toggle(tog),
      .i_kick_float(flt), .i_button_press(btn), .o_cpu_reset(cpu_rst), .o_nmi(nmi),
      .o_pwr_irq(irq), .bus(bus));
   ssrw_asserts #(.RST_CYC(RC), .WDOG_CYC(WC)) i_ssrw_asserts (.i_ref_clk(i_ref_clk),
      .i_srst(i_srst), .rst(bus.rst), .rst_n(bus.rst_n), .wdog_expired_n(bus.wdog_expired_n),
      .wdog_kick_in(bus.wdog_kick_in), .wdog_kick_oe(bus.wdog_kick_oe),
      .manual_reset_n(bus.manual_reset_n));
   always #12.5 i_ref_clk = ~i_ref_clk;
   // Periodic kicks and hang guard
   always @(negedge i_ref_clk) begin
      cyc_n++;
      if (tog) last_k = cyc_n;
      tog <= per != 0 && cyc_n % per == 0;
      if (cyc_n > 20000) begin
         error_cnt++;
         summarize();
      end
   end
   //////////////////////////////////////////////////////////////////////
   function automatic logic warn_of(input logic s);
      return !s;
   endfunction : warn_of
   task automatic cy(input int k);
      repeat (k) @(negedge i_ref_clk);
   endtask : cy
   task automatic chk(input string nm, input logic got, input logic exp);
      n_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("CHECK FAILED %s exp %b got %b", nm, exp, got);
      end
   endtask : chk
   // Reset still held near k, then released
   task automatic rel(input int k);
      cy(k - 6);
      chk("rst held", bus.rst, 1'b1);
      for (n = 0; n < 24 && bus.rst !== 1'b0; n++) cy(1);
      chk("rst free", bus.rst, 1'b0);
      cy(4);
      chk("cpu rst", cpu_rst, 1'b0);
   endtask : rel
   task automatic summarize();
      $display("checks %0d mismatches %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : summarize
   // Main sequence
   initial begin
      void'($urandom(7));
      cy(3);
      i_srst = 0;
      rel(RC);
      $display("power-up done");
      for (i = 0; i < 8; i++) begin
         pfs = 1'($urandom);
         cy(6);
         chk("warn", bus.pwr_fail_warn_n, warn_of(pfs));
         chk("irq", irq, pfs);
      end
      $display("power-fail done");
      sup = 1;
      cy(5 + $urandom % 16);
      chk("uv rst", bus.rst, 1'b1);
      chk("uv wdo", bus.wdog_expired_n, 1'b0);
      sup = 0;
      cy(5);
      chk("uv end", bus.wdog_expired_n, 1'b1);
      cy(RC / 2);
      sup = 1;
      cy(3);
      sup = 0;
      rel(RC + 30); // Expiry tie stretches manual reset past the brownout
      $display("brownout done");
      btn = 1;
      cy(1);
      btn = 0;
      cy(5);
      chk("mr rst", bus.rst, 1'b1);
      rel(RC + 18);
      $display("manual reset done");
      for (i = 0; i < 3; i++) begin
         per = 40 + $urandom % (WC - 60);
         cy(600);
         chk("kicked", bus.wdog_expired_n, 1'b1);
      end
      per = 0;
      for (n = 0; n < WC + 20 && bus.wdog_expired_n !== 1'b0; n++) cy(1);
      chk("timeout", (cyc_n - last_k) inside {[WC:WC + 10]}, 1'b1);
      flt = 1;
      cy(4);
      chk("nmi", nmi, 1'b1);
      cy(4);
      chk("tie rst", bus.rst, 1'b1);
      cy(12);
      rel(RC);
      cy(WC + 50);
      chk("float", bus.wdog_expired_n, 1'b1);
      flt = 0;
      per = 64;
      $display("watchdog done");
      i_srst = 1;
      cy(3);
      i_srst = 0;
      rel(RC);
      $display("second reset done");
      summarize();
   end
endmodule : ssrw_tb_top
